// file: design/pmbus_status_register_bank.sv
// Status flag bytes, summary word and pad-state word of a two-channel bank
//
// Functional notes
// - Summary word low byte equals the channel's one-byte summary.
// - Summary bits 15, 14, 13 flag any output V, output I, input.
// - Any vendor flag sets summary bit 12 and may pull alert.
// - Summary bit 11 is not-power-good; bits 10 to 8 read zero.
// - Output voltage byte: bits 7..1 OV/UV/ceiling/timeouts, bit 0 zero.
// - Output voltage bits 7 down to 1 may pull alert.
// - Writing one to an output voltage bit clears that bit.
// - Output current byte: fault bit 7, warning bit 5, rest zero.
// - Input byte: OV fault 7, UV warning 5, unit off 3.
// - Of the input byte only bit 7 may pull alert.
// - Writing one to input bit 7 clears the overvoltage fault.
// - Temperature byte: OT fault 7, OT warning 6, UT fault 4.
// - Comm/memory/logic byte flags bits 7..3, 1, 0; bit 2 zero.
// - Current, temperature and comm bytes may pull alert when set.
// - Writing one to a supported bit of those bytes clears it.
// - Vendor byte bits 5, 4, 3, 1, 0 as listed; bit 2 zero.
// - Vendor bits 7 and 6 flag internal temperature fault and warning.
// - Pad word bits 15/14 flag slave channels; 13 and 12 zero.
// - Pad bits 11 and 10: current readings invalid, sync disabled.
// - Pad bits 9 and 8 give power-good; slaves report one.
// - Pad bits 7..0 give run and fault drive and levels.
// - Pad word is read-only, two bytes; a host write to it sets the invalid-command flag.
// - Clear-faults clears every status bit at once, releasing alert.
// - A condition still present after clear-faults sets its flag again.
`timescale 1ns/1ps
`include "pmbus_status_cfg.svh"
module pmbus_status_register_bank
  import pmbus_status_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // Command port
  input  wire logic [7:0]  cmd_i,
  input  wire logic        page_i,
  input  wire logic        wr_en_i,
  input  wire flag_byte_t  wr_data_i,
  input  wire logic        rd_en_i,
  output word_t            rd_data_o,
  output logic             rd_valid_o,
  output logic             rd_err_o,
  // Fault and warning conditions
  input  wire chan_flags_t vout_cond_i,
  input  wire chan_flags_t iout_cond_i,
  input  wire chan_flags_t temp_cond_i,
  input  wire chan_flags_t vendor_cond_i,
  input  wire flag_byte_t  input_cond_i,
  input  wire flag_byte_t  cml_cond_i,
  input  wire logic [15:0] int_temp_i,
  input  wire chan_flags_t status_byte_i,
  // Channel state
  input  wire logic [1:0]  pgood_i,
  input  wire logic [1:0]  slave_i,
  input  wire logic        iout_invalid_i,
  input  wire logic [1:0]  run_drive_i,
  input  wire logic [1:0]  fault_drive_i,
  // Pins
  input  wire logic [1:0]  run_pin_i,
  input  wire logic [1:0]  fault_pin_i,
  input  wire logic        sync_dis_pin_i,
  // Alert line, open drain
  output logic             alert_o,
  output logic             alert_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0]  run_s;
  logic [1:0]  fault_s;
  logic        sync_dis_s;

  pin_sync #(.W(5)) u_sync (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .pin_i  ({sync_dis_pin_i, run_pin_i, fault_pin_i}),
    .sync_o ({sync_dis_s, run_s, fault_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  logic        clr_all;
  logic        known_wr;
  logic        known_rd;
  logic        inv_cmd;

  assign clr_all = wr_en_i && (cmd_i == `CMD_CLEAR_FAULTS);

  always_comb begin
    if (cmd_i == `CMD_CLEAR_FAULTS || cmd_i == `CMD_SUMMARY) begin
      known_wr = 1'b1;
    end else if (cmd_i >= `CMD_VOUT && cmd_i <= `CMD_CML) begin
      known_wr = 1'b1;
    end else if (cmd_i == `CMD_VENDOR) begin
      known_wr = 1'b1;
    end else begin
      known_wr = 1'b0;
    end
  end

  always_comb begin
    if (cmd_i >= `CMD_SUMMARY && cmd_i <= `CMD_CML) begin
      known_rd = 1'b1;
    end else if (cmd_i == `CMD_VENDOR || cmd_i == `CMD_PADS) begin
      known_rd = 1'b1;
    end else begin
      known_rd = 1'b0;
    end
  end

  // A write to the read-only pad word counts as an invalid command
  assign inv_cmd = (wr_en_i && !known_wr) || (rd_en_i && !known_rd);

  ////////////////////////////////////////////////////////////////////////
  // Unpaged flag bytes
  flag_byte_t  input_q;
  flag_byte_t  cml_q;
  flag_byte_t  input_w1c;
  flag_byte_t  cml_w1c;
  flag_byte_t  cml_set;

  assign input_w1c = (wr_en_i && cmd_i == `CMD_INPUT) ? wr_data_i : '0;
  assign cml_w1c   = (wr_en_i && cmd_i == `CMD_CML) ? wr_data_i : '0;
  assign cml_set   = cml_cond_i | {inv_cmd, 7'h00};

  sticky_flags #(.SUPP(`INPUT_SUPP)) u_input (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .set_i     (input_cond_i),
    .w1c_i     (input_w1c),
    .clr_all_i (clr_all),
    .flags_o   (input_q)
  );

  sticky_flags #(.SUPP(`CML_SUPP)) u_cml (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .set_i     (cml_set),
    .w1c_i     (cml_w1c),
    .clr_all_i (clr_all),
    .flags_o   (cml_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Paged flag bytes, one set per channel
  chan_flags_t vout_q;
  chan_flags_t iout_q;
  chan_flags_t temp_q;
  chan_flags_t vendor_q;
  word_t       sum_w [2];
  logic        temp_fault;
  logic        temp_warn;

  // Internal temperature is shared, so both channels see it
  assign temp_fault = $signed(int_temp_i) > $signed(`TEMP_FAULT_C);
  assign temp_warn  = $signed(int_temp_i) > $signed(`TEMP_WARN_C);

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic       sel;
    flag_byte_t vend_set;

    assign sel = wr_en_i && (page_i == ch[0]);
    assign vend_set = {temp_fault, temp_warn, vendor_cond_i[ch][5:1],
                       !fault_s[ch]};

    sticky_flags #(.SUPP(`VOUT_SUPP)) u_vout (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .set_i     (vout_cond_i[ch]),
      .w1c_i     ((sel && cmd_i == `CMD_VOUT) ? wr_data_i : '0),
      .clr_all_i (clr_all),
      .flags_o   (vout_q[ch])
    );

    sticky_flags #(.SUPP(`IOUT_SUPP)) u_iout (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .set_i     (iout_cond_i[ch]),
      .w1c_i     ((sel && cmd_i == `CMD_IOUT) ? wr_data_i : '0),
      .clr_all_i (clr_all),
      .flags_o   (iout_q[ch])
    );

    sticky_flags #(.SUPP(`TEMP_SUPP)) u_temp (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .set_i     (temp_cond_i[ch]),
      .w1c_i     ((sel && cmd_i == `CMD_TEMP) ? wr_data_i : '0),
      .clr_all_i (clr_all),
      .flags_o   (temp_q[ch])
    );

    sticky_flags #(.SUPP(`VENDOR_SUPP)) u_vendor (
      .mclk_i    (mclk_i),
      .rstn_i    (rstn_i),
      .set_i     (vend_set),
      .w1c_i     ((sel && cmd_i == `CMD_VENDOR) ? wr_data_i : '0),
      .clr_all_i (clr_all),
      .flags_o   (vendor_q[ch])
    );

    // Input flags are unpaged and summarised into both channels
    assign sum_w[ch] = {|vout_q[ch], |iout_q[ch], |input_q,
                        |vendor_q[ch],
                        !pgood_i[ch], 3'h0,
                        status_byte_i[ch]};
  end

  ////////////////////////////////////////////////////////////////////////
  // Pad-state word
  word_t       pads_w;
  logic [1:0]  pgood_rep;

  // A slave has no own regulation loop, so it reports good
  assign pgood_rep = pgood_i | slave_i;

  assign pads_w = {slave_i[1], slave_i[0], 2'h0,
                   iout_invalid_i, sync_dis_s,
                   pgood_rep[1], pgood_rep[0],
                   run_drive_i[1], run_drive_i[0],
                   run_s[1], run_s[0],
                   fault_drive_i[1], fault_drive_i[0],
                   fault_s[1], fault_s[0]};

  ////////////////////////////////////////////////////////////////////////
  // Read path, answer one cycle after the request
  rd_state_t   rd_state_q;
  word_t       rd_mux;

  always_comb begin
    if (cmd_i == `CMD_SUMMARY) begin
      rd_mux = sum_w[page_i];
    end else if (cmd_i == `CMD_VOUT) begin
      rd_mux = {8'h00, vout_q[page_i]};
    end else if (cmd_i == `CMD_IOUT) begin
      rd_mux = {8'h00, iout_q[page_i]};
    end else if (cmd_i == `CMD_INPUT) begin
      rd_mux = {8'h00, input_q};
    end else if (cmd_i == `CMD_TEMP) begin
      rd_mux = {8'h00, temp_q[page_i]};
    end else if (cmd_i == `CMD_CML) begin
      rd_mux = {8'h00, cml_q};
    end else if (cmd_i == `CMD_VENDOR) begin
      rd_mux = {8'h00, vendor_q[page_i]};
    end else if (cmd_i == `CMD_PADS) begin
      rd_mux = pads_w;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_en_i) begin
      rd_data_o <= rd_mux;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_state_q <= RD_IDLE;
    end else begin
      case (rd_state_q)
        RD_IDLE, RD_DONE, RD_ERR: begin
          if (!rd_en_i) begin
            rd_state_q <= RD_IDLE;
          end else if (known_rd) begin
            rd_state_q <= RD_DONE;
          end else begin
            rd_state_q <= RD_ERR;
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  assign rd_valid_o = (rd_state_q == RD_DONE);
  assign rd_err_o   = (rd_state_q == RD_ERR);

  ////////////////////////////////////////////////////////////////////////
  // Alert line
  logic        alert_any;
  logic        alert_q;

  assign alert_any = |(vout_q[0] & `VOUT_ALERT) |
                     |(vout_q[1] & `VOUT_ALERT) |
                     |(input_q & `INPUT_ALERT) |
                     |iout_q | |temp_q | |cml_q |
                     |vendor_q;

  // Registered so the open-drain enable never glitches
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= alert_any;
    end
  end

  assign alert_o    = 1'b0;
  assign alert_oe_o = alert_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic        no_cond;
  flag_byte_t  sb_sel;
  logic        pg_sel;

  assign sb_sel  = status_byte_i[page_i];
  assign pg_sel  = pgood_i[page_i];
  assign no_cond = !(|vout_cond_i || |iout_cond_i || |temp_cond_i ||
                     |vendor_cond_i || |input_cond_i || |cml_cond_i ||
                     temp_warn || fault_s != 2'h3 || inv_cmd);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_sum_read;
    rd_en_i && cmd_i == `CMD_SUMMARY;
  endsequence

  sequence s_quiet_clear;
    clr_all && no_cond ##1 no_cond;
  endsequence

  property p_low_byte;
    s_sum_read |=> rd_data_o[7:0] == $past(sb_sel) && rd_valid_o;
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("summary low byte differs from one-byte summary");

  property p_sum_high;
    s_sum_read |=> rd_data_o[10:8] == 3'h0 &&
                   rd_data_o[`SUM_NOT_PGOOD] == !$past(pg_sel);
  endproperty
  a_sum_high: assert property (p_sum_high)
    else $error("summary bits 11 to 8 wrong");

  property p_vout_sum;
    (s_sum_read and !page_i) |=> rd_data_o[15] == $past(|vout_q[0]);
  endproperty
  a_vout_sum: assert property (p_vout_sum)
    else $error("summary bit 15 does not follow output voltage flags");

  property p_sticky;
    vout_q[0][7] && !clr_all &&
    !(wr_en_i && !page_i && cmd_i == `CMD_VOUT && wr_data_i[7])
    |=> vout_q[0][7];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("output voltage fault flag dropped by itself");

  property p_w1c;
    wr_en_i && !page_i && cmd_i == `CMD_VOUT && wr_data_i[7] &&
    !vout_cond_i[0][7] |=> !vout_q[0][7];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear output voltage fault");

  property p_reset_again;
    clr_all && input_cond_i[7] |=> input_q[7] ##1 alert_oe_o;
  endproperty
  a_reset_again: assert property (p_reset_again)
    else $error("persisting fault not set again after clear");

  property p_clear_all;
    s_quiet_clear |-> input_q == 8'h00 && cml_q == 8'h00 &&
                      vout_q == '0 ##1 !alert_oe_o;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("clear-faults left flags or alert set");

  property p_unsupported;
    (input_q & ~`INPUT_SUPP) == 8'h00 && cml_q[2] == 1'b0 &&
    vout_q[1][0] == 1'b0;
  endproperty
  a_unsupported: assert property (p_unsupported)
    else $error("unsupported flag bit reads one");

  property p_pads_ro;
    wr_en_i && cmd_i == `CMD_PADS |=> cml_q[`CML_INVALID_CMD];
  endproperty
  a_pads_ro: assert property (p_pads_ro)
    else $error("write to pad word not flagged");

  property p_temp_fault;
    temp_fault |=> vendor_q[0][`VEND_TEMP_FAULT] &&
                   vendor_q[1][`VEND_TEMP_FAULT] ##1 alert_oe_o;
  endproperty
  a_temp_fault: assert property (p_temp_fault)
    else $error("internal overtemperature not flagged");

  property p_pads_read;
    rd_en_i && cmd_i == `CMD_PADS |=> rd_data_o == $past(pads_w) &&
                                      rd_data_o[13:12] == 2'h0;
  endproperty
  a_pads_read: assert property (p_pads_read)
    else $error("pad word read back wrong");

endmodule : pmbus_status_register_bank

// file: design/pmbus_status_cfg.svh
// Command codes, field positions, masks and limits of the status bank
`ifndef PMBUS_STATUS_CFG_SVH
`define PMBUS_STATUS_CFG_SVH

// Command codes
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_SUMMARY      8'h79
`define CMD_VOUT         8'h7A
`define CMD_IOUT         8'h7B
`define CMD_INPUT        8'h7C
`define CMD_TEMP         8'h7D
`define CMD_CML          8'h7E
`define CMD_VENDOR       8'h80
`define CMD_PADS         8'hE5

// Supported bits of each flag byte
`define VOUT_SUPP        8'hFE
`define IOUT_SUPP        8'hA0
`define INPUT_SUPP       8'hA8
`define TEMP_SUPP        8'hD0
`define CML_SUPP         8'hFB
`define VENDOR_SUPP      8'hFB

// Bits allowed to pull the alert line
`define VOUT_ALERT       8'hFE
`define INPUT_ALERT      8'h80

// Field positions
`define CML_INVALID_CMD  7
`define VEND_TEMP_FAULT  7
`define VEND_TEMP_WARN   6
`define VEND_FAULT_LOW   0
`define SUM_NOT_PGOOD    11

// Reset value of every flag byte
`define FLAG_RST         8'h00

// Internal temperature limits in degrees C (160 and 130)
`define TEMP_FAULT_C     16'h00A0
`define TEMP_WARN_C      16'h0082

`endif

// file: design/pmbus_status_pkg.sv
// Types shared by the status register bank
package pmbus_status_pkg;

  typedef logic [7:0]      flag_byte_t;
  typedef logic [1:0][7:0] chan_flags_t;
  typedef logic [15:0]     word_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_DONE = 2'b01,
    RD_ERR  = 2'b10
  } rd_state_t;

endpackage : pmbus_status_pkg

// file: design/pin_sync.sv
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  // Levels
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end

endmodule : pin_sync

// file: design/sticky_flags.sv
// One sticky flag byte with write-one-to-clear and clear-all
`timescale 1ns/1ps
`include "pmbus_status_cfg.svh"
module sticky_flags
  import pmbus_status_pkg::*;
#(
  parameter flag_byte_t SUPP = 8'hFF
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // Events and clears
  input  wire flag_byte_t set_i,
  input  wire flag_byte_t w1c_i,
  input  wire logic       clr_all_i,
  // Flags
  output flag_byte_t      flags_o
);

  flag_byte_t flags_d;

  // Set is applied last so an event never loses against a clear
  always_comb begin
    if (clr_all_i) begin
      flags_d = set_i;
    end else begin
      flags_d = (flags_o & ~w1c_i) | set_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_o <= `FLAG_RST;
    end else begin
      flags_o <= flags_d & SUPP;
    end
  end

endmodule : sticky_flags

// file: verification/host_model.sv
// Host model that issues reads, one-clears and clear-faults to the bank
`timescale 1ns/1ps
module host_model
  import pmbus_status_pkg::*;
(
  // Clock
  input  wire logic  mclk_i,
  // Command port
  output logic [7:0] cmd_o,
  output logic       page_o,
  output logic       wr_en_o,
  output flag_byte_t wr_data_o,
  output logic       rd_en_o,
  input  wire word_t rd_data_i,
  input  wire logic  rd_valid_i,
  input  wire logic  rd_err_i
);
  initial begin
    cmd_o     = 8'h00;
    page_o    = 1'b0;
    wr_en_o   = 1'b0;
    wr_data_o = 8'h00;
    rd_en_o   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write: one-clear mask or clear-faults, taken on the next rising edge
  task automatic send(input logic [7:0] cmd, input logic page,
                      input flag_byte_t data);
    @(negedge mclk_i);
    cmd_o     = cmd;
    page_o    = page;
    wr_data_o = data;
    wr_en_o   = 1'b1;
    @(negedge mclk_i);
    wr_en_o   = 1'b0;
    // Released data lines must not keep looking valid
    wr_data_o = ~data;
  endtask : send

  ////////////////////////////////////////////////////////////////////////////
  // Read: answer stands from the taking edge on, sampled on the next falling edge
  task automatic read(input logic [7:0] cmd, input logic page,
                      output word_t data, output logic ok, output logic err);
    @(negedge mclk_i);
    cmd_o   = cmd;
    page_o  = page;
    rd_en_o = 1'b1;
    @(negedge mclk_i);
    rd_en_o = 1'b0;
    cmd_o   = ~cmd;
    data    = rd_data_i;
    ok      = rd_valid_i;
    err     = rd_err_i;
  endtask : read
endmodule : host_model

// file: verification/tb_top.sv
// Self-checking testbench of the status register bank
`timescale 1ns/1ps
`include "pmbus_status_cfg.svh"
module tb_top
  import pmbus_status_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  cmd;
  logic        page, wr_en, rd_en, rd_valid, rd_err, alert, alert_oe;
  flag_byte_t  wr_data, in_c = 8'h00, cml_c = 8'h00;
  word_t       rd_data;
  chan_flags_t vout_c = '0, iout_c = '0, temp_c = '0, vend_c = '0;
  chan_flags_t sbyte = '0;
  logic [15:0] itemp = 16'h0019;
  logic [1:0]  pg = 2'b11, sl = 2'b00, rdrv = 2'b00, fdrv = 2'b00;
  logic [1:0]  rpin = 2'b11, fpin = 2'b11;
  logic        ioinv = 1'b0, syncdis = 1'b0;
  int          errors = 0, compares = 0;
  // Alert line has a pull-up on the board
  wire         alert_n = alert_oe ? alert : 1'b1;
  logic [7:0]  cmds [6] = '{`CMD_VOUT, `CMD_IOUT, `CMD_INPUT, `CMD_TEMP,
                           `CMD_CML, `CMD_VENDOR};
  // Vendor conditions only reach bits 5:1, bit 2 unsupported
  flag_byte_t  exps [6] = '{`VOUT_SUPP, `IOUT_SUPP, `INPUT_SUPP, `TEMP_SUPP,
                           `CML_SUPP, 8'h3A};

  always #25 mclk_i = ~mclk_i;

  pmbus_status_register_bank dut (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .cmd_i(cmd), .page_i(page),
    .wr_en_i(wr_en), .wr_data_i(wr_data), .rd_en_i(rd_en),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_err_o(rd_err),
    .vout_cond_i(vout_c), .iout_cond_i(iout_c), .temp_cond_i(temp_c),
    .vendor_cond_i(vend_c), .input_cond_i(in_c), .cml_cond_i(cml_c),
    .int_temp_i(itemp), .status_byte_i(sbyte), .pgood_i(pg), .slave_i(sl),
    .iout_invalid_i(ioinv), .run_drive_i(rdrv), .fault_drive_i(fdrv),
    .run_pin_i(rpin), .fault_pin_i(fpin), .sync_dis_pin_i(syncdis),
    .alert_o(alert), .alert_oe_o(alert_oe));

  host_model host (
    .mclk_i(mclk_i), .cmd_o(cmd), .page_o(page), .wr_en_o(wr_en),
    .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .rd_err_i(rd_err));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input word_t got, input word_t exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] c, input logic p, input word_t exp);
    word_t d;
    logic  ok, er;
    host.read(c, p, d, ok, er);
    chk(d, exp);
    chk({14'h0000, ok, er}, 16'h0002);
  endtask : rd_chk

  task automatic set_cond(input int k, input logic p, input flag_byte_t v);
    case (k)
      0: vout_c[p] = v;
      1: iout_c[p] = v;
      2: in_c = v;
      3: temp_c[p] = v;
      4: cml_c = v;
      default: vend_c[p] = v;
    endcase
  endtask : set_cond

  // One-cycle condition: whatever stays set afterwards is sticky
  task automatic pulse(input int k, input logic p, input flag_byte_t v);
    @(negedge mclk_i);
    set_cond(k, p, v);
    @(negedge mclk_i);
    set_cond(k, p, 8'h00);
  endtask : pulse

  task automatic chk_alert(input logic exp);
    chk({15'h0000, alert_n}, {15'h0000, exp});
  endtask : chk_alert

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cleared;
    host.send(`CMD_CLEAR_FAULTS, 1'b0, 8'h00);
    for (int k = 0; k < 6; k++) begin
      rd_chk(cmds[k], 1'b0, 16'h0000);
    end
    chk_alert(1'b1);
  endtask : t_cleared

  task automatic t_bytes;
    for (int k = 0; k < 6; k++) begin
      pulse(k, 1'b1, 8'hFF);
      rd_chk(cmds[k], 1'b1, {8'h00, exps[k]});
      chk_alert(1'b0);
      host.send(cmds[k], 1'b1, 8'h80);
      rd_chk(cmds[k], 1'b1, {8'h00, exps[k] & 8'h7F});
      chk_alert(k == 2);
      host.send(cmds[k], 1'b1, 8'hFF);
      rd_chk(cmds[k], 1'b1, 16'h0000);
      chk_alert(1'b1);
    end
  endtask : t_bytes

  task automatic t_persist;
    pulse(0, 1'b0, 8'hFF);
    pulse(3, 1'b1, 8'hFF);
    @(negedge mclk_i);
    iout_c[0] = 8'h80;
    host.send(`CMD_CLEAR_FAULTS, 1'b0, 8'h00);
    rd_chk(`CMD_VOUT, 1'b0, 16'h0000);
    rd_chk(`CMD_TEMP, 1'b1, 16'h0000);
    rd_chk(`CMD_IOUT, 1'b0, 16'h0080);
    chk_alert(1'b0);
    iout_c[0] = 8'h00;
    t_cleared();
  endtask : t_persist

  task automatic t_summary;
    @(negedge mclk_i);
    sbyte = {8'h5A, 8'hC3};
    pg    = 2'b01;
    pulse(5, 1'b1, 8'h02);
    pulse(2, 1'b0, 8'h20);
    rd_chk(`CMD_SUMMARY, 1'b1, 16'h385A);
    rd_chk(`CMD_SUMMARY, 1'b0, 16'h20C3);
    host.send(`CMD_SUMMARY, 1'b1, 8'hFF);
    rd_chk(`CMD_SUMMARY, 1'b1, 16'h385A);
    pulse(0, 1'b0, 8'h40);
    pulse(1, 1'b0, 8'h20);
    rd_chk(`CMD_SUMMARY, 1'b0, 16'hE0C3);
    pg = 2'b11;
    t_cleared();
  endtask : t_summary

  task automatic t_int_temp;
    logic [15:0] temps [3] = '{16'h00A1, 16'h00A0, 16'h0082};
    flag_byte_t  tx [3] = '{8'hC0, 8'h40, 8'h00};
    for (int k = 0; k < 3; k++) begin
      @(negedge mclk_i);
      itemp = temps[k];
      @(negedge mclk_i);
      itemp = 16'h0019;
      rd_chk(`CMD_VENDOR, 1'b0, {8'h00, tx[k]});
      rd_chk(`CMD_VENDOR, 1'b1, {8'h00, tx[k]});
      t_cleared();
    end
  endtask : t_int_temp

  task automatic t_pads;
    word_t d;
    logic  ok, er;
    @(negedge mclk_i);
    {sl, pg, ioinv, syncdis} = {2'b10, 2'b00, 1'b1, 1'b1};
    {rdrv, fdrv, rpin, fpin} = {2'b01, 2'b10, 2'b10, 2'b01};
    repeat (4) @(negedge mclk_i);
    rd_chk(`CMD_PADS, 1'b0, 16'h8E69);
    rd_chk(`CMD_VENDOR, 1'b1, 16'h0001);
    rd_chk(`CMD_VENDOR, 1'b0, 16'h0000);
    host.send(`CMD_PADS, 1'b0, 8'hFF);
    rd_chk(`CMD_PADS, 1'b0, 16'h8E69);
    rd_chk(`CMD_CML, 1'b0, 16'h0080);
    host.send(`CMD_CML, 1'b0, 8'h80);
    host.read(8'h55, 1'b0, d, ok, er);
    chk(d, 16'h0000);
    chk({14'h0000, ok, er}, 16'h0001);
    rd_chk(`CMD_CML, 1'b0, 16'h0080);
    {sl, pg, ioinv, syncdis} = {2'b00, 2'b11, 1'b0, 1'b0};
    {rdrv, fdrv, rpin, fpin} = {2'b00, 2'b00, 2'b11, 2'b11};
    repeat (4) @(negedge mclk_i);
    t_cleared();
  endtask : t_pads

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (4) @(negedge mclk_i);
    rstn_i = 1'b1;
    // Pin synchronisers start low, so wait before the first clear
    repeat (3) @(negedge mclk_i);
    t_cleared();
    t_bytes();
    t_persist();
    t_summary();
    t_int_temp();
    t_pads();
    report_and_stop();
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule : tb_top
